// File: rtl/ppfd_decoder.sv
// Function
// (RULE_01) port use follows four function pins
// (RULE_02) 0000: data, address, control fields
// (RULE_03) control picks read/write and 8/16 width
// (RULE_04) address selects register, data carries contents
// (RULE_05) 0001: low byte is serial lines
// (RULE_06) 0010: whole port into frequency word
// (RULE_07) 0011: halves swapped into frequency word
// (RULE_08) 0100: phase high half, amplitude low
// (RULE_09) 0101: amplitude high half, phase low
// (RULE_10) 0110-1001: frequency high 24, byte lanes
// (RULE_11) 1010-1101: frequency low 24, byte lanes
// (RULE_12) amplitude changes only with keying enable
// (RULE_13) only amplitude bits 11:0 matter
// (RULE_14) lane 31 is msb, lane 0 lsb
// (RULE_15) codes 1110, 1111 give no function
// (RULE_16) direct modes sample every 24 clocks
// (RULE_17) streaming bypasses update strobe, else wait
// (RULE_18) unmapped word bits stay unchanged
`timescale 1ns/100ps
`default_nettype none
module ppfd_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } ppfd_fifo_st_t;
    ppfd_fifo_st_t st, next_st;
    logic push, pop;

    assign in_ready  = (st.cnt != (PW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointers wrap at depth so non power-of-two depths still work
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = (st.wp == PW'(DEPTH-1)) ? '0 : st.wp + PW'(1);
        end
        if (pop)
            next_st.rp = (st.rp == PW'(DEPTH-1)) ? '0 : st.rp + PW'(1);
        next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end
endmodule : ppfd_fifo

module ppfd_decoder
    import ppfd_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int SAMPLE_CNT = ppfd_pkg::SAMPLE_DIV
) (
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // function pins and 32-lane port
    input  wire logic [3:0]              func_sel,
    input  wire logic [ppfd_pkg::PORT_W-1:0] port_in,
    output logic [ppfd_pkg::PORT_W-1:0]  port_out,
    output logic [ppfd_pkg::PORT_W-1:0]  port_oe,
    input  wire logic                    io_update,
    // register-programming side
    output logic                         reg_req_valid,
    output ppfd_pkg::ppfd_reg_req_t      reg_req,
    input  wire logic [ppfd_pkg::HALF_W-1:0] reg_rdata,
    // serial engine side
    output ppfd_pkg::ppfd_serial_t       serial_lines,
    input  wire logic                    ser_sdo,
    input  wire logic                    ser_sdio_out,
    input  wire logic                    ser_sdio_oe,
    // synthesis core side
    input  wire logic                    core_ready,
    output logic                         core_load,
    output logic [ppfd_pkg::FTW_W-1:0]   core_ftw,
    output logic [ppfd_pkg::POW_W-1:0]   core_pow,
    output logic [ppfd_pkg::AMP_USED-1:0] core_amp
);
    import ppfd_pkg::*;

    localparam int FW = $bits(ppfd_word_t);

    typedef struct packed {
        logic [3:0]        func_s1, func_s2;
        logic [PORT_W-1:0] port_s1, port_s2;
        logic              upd_s1, upd_s2, upd_d;
        logic [CTL_W-1:0]  ctl_d;
        logic [4:0]        cnt;
        logic              tick;
        ppfd_word_t        staged;
        logic              push_pend;
        logic [31:0]       cff;
        logic [31:0]       prdata;
        logic              pready, pslverr;
        logic [PORT_W-1:0] port_out, port_oe;
        logic              req_valid;
        ppfd_reg_req_t     req;
        ppfd_serial_t      ser;
        logic              core_load;
        logic [FTW_W-1:0]  freq_tuning_word;
        logic [POW_W-1:0]  phase_offset_word;
        logic [AMP_USED-1:0] amplitude_word;
    } ppfd_st_t;
    ppfd_st_t st, next_st;

    logic       fifo_in_ready, fifo_out_valid, pop;
    ppfd_word_t fifo_out;
    ppfd_func_t fn;

    // true for every direct-modulation code
    function automatic logic is_direct(input logic [3:0] f);
        return (f >= FN_FTW_FULL) && (f <= FN_FL_PLO);
    endfunction : is_direct

    // lane mapping; bits not named by a code are kept from the old word
    function automatic ppfd_word_t map_port(input ppfd_func_t f, input logic [PORT_W-1:0] p,
                                            input ppfd_word_t w);
        ppfd_word_t n;
        n = w; // RULE_18
        case (f)
            FN_FTW_FULL: n.freq_tuning_word = p; // RULE_06 RULE_14
            FN_FTW_SWAP: n.freq_tuning_word = {p[15:0], p[31:16]}; // RULE_07
            FN_POW_AMP:
            begin
                n.phase_offset_word = p[31:16]; // RULE_08
                n.amplitude_word[AMP_USED-1:0] = p[AMP_USED-1:0];
            end
            FN_AMP_POW:
            begin
                n.amplitude_word[AMP_USED-1:0] = p[27:16]; // RULE_09
                n.phase_offset_word = p[15:0];
            end
            FN_FH_AHI, FN_FH_PHI, FN_FH_ALO, FN_FH_PLO:
                n.freq_tuning_word[31:8] = p[31:8]; // RULE_10
            FN_FL_AHI, FN_FL_PHI, FN_FL_ALO, FN_FL_PLO:
                n.freq_tuning_word[23:0] = p[31:8]; // RULE_11
            default: n = w;
        endcase
        // low byte lane of the partial modes: amp hi, phase hi, amp lo, phase lo
        case (f)
            FN_FH_AHI, FN_FL_AHI: n.amplitude_word[15:8] = p[7:0]; // RULE_10 RULE_11
            FN_FH_PHI, FN_FL_PHI: n.phase_offset_word[15:8] = p[7:0];
            FN_FH_ALO, FN_FL_ALO: n.amplitude_word[7:0]  = p[7:0];
            FN_FH_PLO, FN_FL_PLO: n.phase_offset_word[7:0]  = p[7:0];
            default: ;
        endcase
        return n;
    endfunction : map_port

    assign fn  = ppfd_func_t'(st.func_s2);
    assign pop = fifo_out_valid && core_ready;

    ppfd_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (st.push_pend),
        .in_ready  (fifo_in_ready),
        .in_data   (st.staged),
        .out_valid (fifo_out_valid),
        .out_ready (core_ready),
        .out_data  (fifo_out)
    );

    // whole next state; pins pass two flops before any logic looks at them
    always_comb
    begin
        logic [CTL_W-1:0] ctl;
        logic             stream, upd_edge;
        next_st = st;
        ctl      = st.port_s2[CTL_W-1:0];
        stream   = st.cff[CFF_STREAM_BIT];
        upd_edge = st.upd_s2 && !st.upd_d;
        next_st.func_s1 = func_sel;
        next_st.func_s2 = st.func_s1;
        next_st.port_s1 = port_in;
        next_st.port_s2 = st.port_s1;
        next_st.upd_s1  = io_update;
        next_st.upd_s2  = st.upd_s1;
        next_st.upd_d   = st.upd_s2;
        next_st.ctl_d   = (fn == FN_REG_PROG) ? ctl : '0;

        // sample slot counter, one tick per 24 clocks
        next_st.tick = (st.cnt == 5'(SAMPLE_CNT-2)); // RULE_16
        next_st.cnt  = (st.cnt == 5'(SAMPLE_CNT-1)) ? '0 : st.cnt + 5'd1;

        // direct modes load the word registers on each tick
        if (st.tick && is_direct(fn)) // RULE_01 RULE_16
            next_st.staged = map_port(fn, st.port_s2, st.staged);
        // the core sees new words per tick when streaming, else only on update
        if (st.push_pend && fifo_in_ready)
            next_st.push_pend = 1'b0;
        if ((stream && st.tick && is_direct(fn)) || (!stream && upd_edge)) // RULE_17
            next_st.push_pend = 1'b1;

        // port lanes: defaults quiet, so the unused codes drive nothing
        next_st.port_out  = '0;
        next_st.port_oe   = '0; // RULE_15
        next_st.req_valid = 1'b0;
        case (fn) // RULE_01
            FN_REG_PROG:
            begin
                // a request is raised on the rising edge of the write or read bit
                if ((ctl[CTL_WR] && !st.ctl_d[CTL_WR]) || (ctl[CTL_RD] && !st.ctl_d[CTL_RD]))
                begin
                    next_st.req_valid   = 1'b1; // RULE_02
                    next_st.req.is_read = ctl[CTL_RD]; // RULE_03
                    next_st.req.wide    = ctl[CTL_WIDE];
                    next_st.req.addr    = st.port_s2[RP_ADDR_LO +: ADDR_W]; // RULE_04
                    next_st.req.data    = ctl[CTL_WIDE] ? st.port_s2[RP_DATA_LO +: HALF_W]
                                        : {8'h00, st.port_s2[RP_DATA_LO +: BYTE_W]}; // RULE_03
                end
                // while read is held the data lanes carry the register contents
                if (ctl[CTL_RD])
                begin
                    next_st.port_out[RP_DATA_LO +: HALF_W] = reg_rdata; // RULE_04
                    next_st.port_oe[RP_DATA_LO +: BYTE_W]  = {BYTE_W{1'b1}};
                    if (ctl[CTL_WIDE])
                        next_st.port_oe[RP_DATA_LO+BYTE_W +: BYTE_W] = {BYTE_W{1'b1}};
                end
            end
            FN_SERIAL:
            begin
                // upper 24 lanes ignored, low byte goes to the serial engine
                next_st.ser.cs_n       = st.port_s2[SER_CS_N]; // RULE_05
                next_st.ser.sclk       = st.port_s2[SER_SCLK];
                next_st.ser.sdio       = st.port_s2[SER_SDIO];
                next_st.ser.sync_abort = st.port_s2[SER_SYNC];
                next_st.port_out[SER_SDO]  = ser_sdo;
                next_st.port_oe[SER_SDO]   = 1'b1;
                next_st.port_out[SER_SDIO] = ser_sdio_out;
                next_st.port_oe[SER_SDIO]  = ser_sdio_oe;
            end
            default: ;
        endcase
        // serial engine sees an idle, deselected link outside serial mode
        if (fn != FN_SERIAL)
        begin
            next_st.ser = '{cs_n: 1'b1, sclk: 1'b0, sdio: 1'b0, sync_abort: 1'b0};
        end

        // core side takes one word per pop
        next_st.core_load = pop;
        if (pop)
        begin
            next_st.freq_tuning_word = fifo_out.freq_tuning_word;
            next_st.phase_offset_word = fifo_out.phase_offset_word;
            if (st.cff[CFF_AKE_BIT]) // RULE_12
                next_st.amplitude_word = fifo_out.amplitude_word[AMP_USED-1:0]; // RULE_13
        end

        // apb: decode in setup, answer in the access cycle with no wait
        next_st.pready  = psel && !penable;
        next_st.pslverr = 1'b0; // error stands only with pready, so the pin needs no gate
        if (psel && !penable)
        begin
            next_st.prdata  = '0;
            case (paddr)
                OFS_CFF:    next_st.prdata = st.cff;
                OFS_STATUS: next_st.prdata = {26'h0, st.push_pend, fifo_out_valid,
                                              !fifo_in_ready, 1'b0, 2'h0} | {28'h0, st.func_s2};
                OFS_FTW:    next_st.prdata = st.staged.freq_tuning_word;
                OFS_PWAMP:  next_st.prdata = {st.staged.phase_offset_word, st.staged.amplitude_word};
                OFS_REQ:    next_st.prdata = {6'h0, st.req};
                default:    next_st.pslverr = 1'b1;
            endcase
        end
        // writes take effect at the access edge only
        if (psel && penable && st.pready && pwrite && (paddr == OFS_CFF))
            next_st.cff = pwdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st        <= '0;
            st.cff    <= CFF_RESET;
            st.ser    <= '{cs_n: 1'b1, sclk: 1'b0, sdio: 1'b0, sync_abort: 1'b0};
        end
        else
            st <= next_st;
    end

    assign prdata        = st.prdata;
    assign pready        = st.pready;
    assign pslverr       = st.pslverr;
    assign port_out      = st.port_out;
    assign port_oe       = st.port_oe;
    assign reg_req_valid = st.req_valid;
    assign reg_req       = st.req;
    assign serial_lines  = st.ser;
    assign core_load     = st.core_load;
    assign core_ftw      = st.freq_tuning_word;
    assign core_pow      = st.phase_offset_word;
    assign core_amp      = st.amplitude_word;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_unused_quiet: assert property ((fn == FN_UNUSED_E || fn == FN_UNUSED_F) |=> port_oe == '0) // RULE_15
        else $error("unused code drives port");
    chk_tick_spacing: assert property (st.tick |-> ##SAMPLE_CNT st.tick) // RULE_16
        else $error("sample slot spacing wrong");
    chk_tick_gap: assert property (st.tick |=> (!st.tick) [*2]) // RULE_16
        else $error("sample ticks too close");
    chk_full_ftw: assert property (st.tick && fn == FN_FTW_FULL |=> st.staged.freq_tuning_word == $past(st.port_s2)) // RULE_06
        else $error("full frequency map wrong");
    chk_swap_ftw: assert property (st.tick && fn == FN_FTW_SWAP
        |=> st.staged.freq_tuning_word == {$past(st.port_s2[15:0]), $past(st.port_s2[31:16])}) // RULE_07
        else $error("swapped frequency map wrong");
    chk_pow_amp: assert property (st.tick && fn == FN_POW_AMP
        |=> st.staged.phase_offset_word == $past(st.port_s2[31:16]) && st.staged.amplitude_word[11:0] == $past(st.port_s2[11:0])) // RULE_08
        else $error("phase/amplitude map wrong");
    chk_partial_keep: assert property (st.tick && fn == FN_FH_AHI
        |=> st.staged.phase_offset_word == $past(st.staged.phase_offset_word) && st.staged.amplitude_word[7:0] == $past(st.staged.amplitude_word[7:0])) // RULE_18
        else $error("partial mode touched other bits");
    chk_amp_gate: assert property (!st.cff[CFF_AKE_BIT] |=> core_amp == $past(core_amp)) // RULE_12
        else $error("amplitude moved without keying enable");
    chk_amp_low: assert property (pop && st.cff[CFF_AKE_BIT] |=> core_amp == $past(fifo_out.amplitude_word[11:0])) // RULE_13
        else $error("amplitude bits wrong");
    chk_no_stream_hold: assert property (!st.cff[CFF_STREAM_BIT] && !(st.upd_s2 && !st.upd_d)
        && !st.push_pend |=> !st.push_pend) // RULE_17
        else $error("word passed without update");
    chk_reg_addr: assert property (reg_req_valid |-> reg_req.addr == $past(st.port_s2[15:8])) // RULE_04
        else $error("register address wrong");
    chk_serial_route: assert property (fn == FN_SERIAL |=> serial_lines.sclk == $past(st.port_s2[1])) // RULE_05
        else $error("serial clock not routed");

    cov_full_word: cover property (st.tick && fn == FN_FTW_FULL);
    cov_fifo_full: cover property (!fifo_in_ready && st.push_pend);
    cov_update_push: cover property (!st.cff[CFF_STREAM_BIT] && $rose(st.push_pend));
    cov_reg_write: cover property (reg_req_valid && !reg_req.is_read);
endmodule : ppfd_decoder
`default_nettype wire

// File: shared/ppfd_pkg.sv
`default_nettype none
package ppfd_pkg;
    // port and parameter word widths
    localparam int PORT_W   = 32;
    localparam int FTW_W    = 32;
    localparam int POW_W    = 16;
    localparam int AMP_W    = 16;
    localparam int AMP_USED = 12;
    localparam int ADDR_W   = 8;
    localparam int HALF_W   = 16;
    localparam int BYTE_W   = 8;

    // function-select codes, pins F[3:0]
    typedef enum logic [3:0] {
        FN_REG_PROG = 4'h0, FN_SERIAL   = 4'h1, FN_FTW_FULL = 4'h2, FN_FTW_SWAP = 4'h3,
        FN_POW_AMP  = 4'h4, FN_AMP_POW  = 4'h5, FN_FH_AHI   = 4'h6, FN_FH_PHI   = 4'h7,
        FN_FH_ALO   = 4'h8, FN_FH_PLO   = 4'h9, FN_FL_AHI   = 4'ha, FN_FL_PHI   = 4'hb,
        FN_FL_ALO   = 4'hc, FN_FL_PLO   = 4'hd, FN_UNUSED_E = 4'he, FN_UNUSED_F = 4'hf
    } ppfd_func_t;

    // register-programming field positions on the port word
    localparam int RP_DATA_LO = 16;
    localparam int RP_ADDR_LO = 8;
    localparam int CTL_WR     = 0;
    localparam int CTL_RD     = 1;
    localparam int CTL_WIDE   = 2;
    localparam int CTL_W      = 3;

    // serial lines on the low byte
    localparam int SER_CS_N = 0;
    localparam int SER_SCLK = 1;
    localparam int SER_SDIO = 2;
    localparam int SER_SDO  = 3;
    localparam int SER_SYNC = 4;

    // apb map
    localparam logic [7:0] OFS_CFF    = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FTW    = 8'h08;
    localparam logic [7:0] OFS_PWAMP  = 8'h0c;
    localparam logic [7:0] OFS_REQ    = 8'h10;
    localparam int CFF_AKE_BIT    = 8;
    localparam int CFF_STREAM_BIT = 17;
    localparam logic [31:0] CFF_RESET = 32'h0000_0000;

    // time of one sample slot: 24 system-clock periods
    localparam int SAMPLE_DIV = 24;

    typedef struct packed {
        logic [FTW_W-1:0] freq_tuning_word;
        logic [POW_W-1:0] phase_offset_word;
        logic [AMP_W-1:0] amplitude_word;
    } ppfd_word_t;

    typedef struct packed {
        logic              is_read;
        logic              wide;
        logic [ADDR_W-1:0] addr;
        logic [HALF_W-1:0] data;
    } ppfd_reg_req_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdio;
        logic sync_abort;
    } ppfd_serial_t;
endpackage : ppfd_pkg
`default_nettype wire

// File: verification/ppfd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ppfd_host_model (
    // clock
    input  wire logic                        pclk,
    // lanes the device may drive back
    input  wire logic [ppfd_pkg::PORT_W-1:0] port_out,
    input  wire logic [ppfd_pkg::PORT_W-1:0] port_oe,
    // pins the host drives
    output logic [3:0]                       func_sel,
    output logic [ppfd_pkg::PORT_W-1:0]      port_in,
    output logic                             io_update
);
    import ppfd_pkg::*;

    logic [PORT_W-1:0] host_drv;

    // wire level: a lane the device enables carries the device's value
    assign port_in = (port_oe & port_out) | (~port_oe & host_drv);

    // pins idle on an unused code so nothing is decoded before the first put
    initial
    begin
        func_sel  = 4'hf;
        host_drv  = 32'h0;
        io_update = 1'b0;
    end

    // hold a code and a word for n more cycles; both stay put afterwards
    task automatic put(input logic [3:0] fn, input logic [31:0] w, input int n);
        @(posedge pclk);
        func_sel <= fn;
        host_drv <= w;
        repeat (n) @(posedge pclk);
    endtask : put

    // strobe held three cycles so the two-flop synchroniser cannot miss it
    task automatic strobe;
        @(posedge pclk);
        io_update <= 1'b1;
        repeat (3) @(posedge pclk);
        io_update <= 1'b0;
    endtask : strobe
endmodule : ppfd_host_model
`default_nettype wire

// File: verification/ppfd_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        n_checks++; \
        if ((got) !== (ex)) \
        begin \
            errors++; \
            $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
        end \
    end
module ppfd_decoder_tb;
    import ppfd_pkg::*;
    // short sample slot keeps the run brief; the put holds in step and t_update derive from it
    localparam int SC = 6;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, err, akey;
    logic          io_update, reg_req_valid, ser_sdo, ser_sdio_out, ser_sdio_oe;
    logic          core_ready, core_load;
    logic [3:0]    func_sel;
    logic [7:0]    paddr;
    logic [11:0]   core_amp;
    logic [15:0]   reg_rdata, core_pow, exp_pow, exp_amp, stg_amp;
    logic [31:0]   pwdata, prdata, port_in, port_out, port_oe, rd, core_ftw, exp_ftw;
    ppfd_reg_req_t reg_req;
    ppfd_serial_t  serial_lines;
    int            errors, n_checks, nreq;

    // 50 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // device under test, every pin live
    ppfd_decoder #(.FIFO_DEPTH(8), .SAMPLE_CNT(SC)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .func_sel(func_sel), .port_in(port_in),
        .port_out(port_out), .port_oe(port_oe), .io_update(io_update),
        .reg_req_valid(reg_req_valid), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .serial_lines(serial_lines), .ser_sdo(ser_sdo), .ser_sdio_out(ser_sdio_out),
        .ser_sdio_oe(ser_sdio_oe), .core_ready(core_ready), .core_load(core_load),
        .core_ftw(core_ftw), .core_pow(core_pow), .core_amp(core_amp)
    );

    // far-side host
    ppfd_host_model host (
        .pclk(pclk), .port_out(port_out), .port_oe(port_oe),
        .func_sel(func_sel), .port_in(port_in), .io_update(io_update)
    );

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait count assumed; only the watchdog ends a hung transfer
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // reference mapping of port word onto the expected core words
    function automatic void apply(input logic [3:0] fn, input logic [31:0] w);
        if (fn == 4'h2)
            exp_ftw = w;
        if (fn == 4'h3)
            exp_ftw = {w[15:0], w[31:16]};
        if (fn == 4'h4)
            {exp_pow, stg_amp[11:0]} = {w[31:16], w[11:0]};
        if (fn == 4'h5)
            {stg_amp[11:0], exp_pow} = {w[27:16], w[15:0]};
        if (fn >= 4'h6 && fn <= 4'h9)
            exp_ftw[31:8] = w[31:8];
        if (fn >= 4'ha && fn <= 4'hd)
            exp_ftw[23:0] = w[31:8];
        // even codes feed amplitude, odd ones phase; bit 1 picks the upper byte
        if (fn >= 4'h6 && fn <= 4'hd && !fn[0])
            stg_amp[{fn[1], 3'b000} +: 8] = w[7:0];
        if (fn >= 4'h6 && fn <= 4'hd && fn[0])
            exp_pow[{fn[1], 3'b000} +: 8] = w[7:0];
        if (akey)
            exp_amp = stg_amp;
    endfunction : apply

    // hold a word past one sample slot, then compare all core words
    task automatic step(input logic [3:0] fn, input logic [31:0] w);
        host.put(fn, w, SC + 4);
        repeat (6) @(posedge pclk);
        apply(fn, w);
        `CHK("core ftw", exp_ftw, core_ftw)
        `CHK("core pow", exp_pow, core_pow)
        `CHK("core amp", exp_amp[11:0], core_amp)
    endtask : step

    // register reset, write-back, pin status and an unmapped address
    task automatic t_apb;
        apb(1'b0, OFS_CFF, 32'h0);
        `CHK("cff reset", CFF_RESET, rd)
        apb(1'b1, OFS_CFF, 32'h0002_0100);
        akey = 1'b1;
        apb(1'b0, OFS_CFF, 32'h0);
        `CHK("cff back", 32'h0002_0100, rd)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("func pins", 4'hf, rd[3:0])
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    endtask : t_apb

    // every lane mapping in turn, then an unused code that must change nothing
    task automatic t_direct;
        for (int i = 2; i <= 14; i++)
            step(4'(i), 32'h9e37_79b9 ^ {8{4'(i)}});
        `CHK("unused oe", 32'h0, port_oe)
    endtask : t_direct

    // keying off: amplitude holds while phase still moves
    task automatic t_keying;
        apb(1'b1, OFS_CFF, 32'h0002_0000);
        akey = 1'b0;
        step(4'h5, 32'h0abc_1234);
        apb(1'b1, OFS_CFF, 32'h0002_0100);
        akey = 1'b1;
        step(4'h8, 32'h1111_2255);
    endtask : t_keying

    // streaming off: words wait in the registers for the update strobe
    task automatic t_update;
        apb(1'b1, OFS_CFF, 32'h0000_0100);
        host.put(4'h2, 32'h1357_9bdf, SC + 4);
        repeat (6) @(posedge pclk);
        `CHK("held ftw", exp_ftw, core_ftw)
        host.strobe;
        repeat (8) @(posedge pclk);
        apply(4'h2, 32'h1357_9bdf);
        `CHK("updated ftw", exp_ftw, core_ftw)
        `CHK("updated amp", exp_amp[11:0], core_amp)
        apb(1'b1, OFS_CFF, 32'h0002_0100);
    endtask : t_update

    // a held wide write, then a narrow read that turns the data lanes around
    task automatic t_regprog;
        host.put(4'h0, 32'ha5c3_5a05, 8);
        `CHK("write req", 26'h15a_a5c3, reg_req)
        host.put(4'h0, 32'h0000_3302, 8);
        `CHK("read req", 26'h233_0000, reg_req)
        `CHK("read oe", 32'h00ff_0000, port_oe)
        `CHK("read lanes", 32'h00ef_0000, port_out & port_oe)
        `CHK("requests", 2, nreq)
    endtask : t_regprog

    // low byte drives the serial lines; sdo turned back onto lane 3
    task automatic t_serial;
        host.put(4'h1, 32'hffff_ff16, 6);
        `CHK("serial lines", 4'h7, serial_lines)
        `CHK("serial oe", 32'h0000_0008, port_oe)
        `CHK("sdo lane", 32'h0000_0008, port_out & port_oe)
        host.put(4'hf, 32'h0, 6);
        `CHK("serial idle", 4'h8, serial_lines)
        `CHK("idle oe", 32'h0, port_oe)
    endtask : t_serial

    // counts request pulses so a held control level cannot hide a repeat
    always @(posedge pclk)
    begin
        if (reg_req_valid === 1'b1)
            nreq <= nreq + 1;
    end

    // one closing point for both the finished and the timed-out run
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    // reset, then the scenarios in order
    initial
    begin
        presetn      <= 1'b0;
        psel         <= 1'b0;
        penable      <= 1'b0;
        pwrite       <= 1'b0;
        paddr        <= 8'h00;
        pwdata       <= 32'h0;
        reg_rdata    <= 16'hbeef;
        ser_sdo      <= 1'b1;
        ser_sdio_out <= 1'b0;
        ser_sdio_oe  <= 1'b0;
        core_ready   <= 1'b1;
        {exp_ftw, exp_pow, exp_amp, stg_amp} = '0;
        akey = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_apb;
        t_direct;
        t_keying;
        t_update;
        t_regprog;
        t_serial;
        give_verdict;
    end

    // watchdog: the scenarios need well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge pclk);
        errors++;
        give_verdict;
    end
endmodule : ppfd_decoder_tb
`default_nettype wire
